// >>> core/nvsram_host_ctrl.sv
// Host bus controller that drives an 8K x 8 nonvolatile SRAM through its pins
// Summary of operation
// - Host keeps address stable from write start until select or write rises.
// - Byte is stored at write's trailing edge; host holds data valid there.
// - Host keeps output enable high during writes; device drops drivers otherwise.
// - Host keeps write or select high when power-up recall ends.
// - Reads of 0000,1555,0AAA,1FFF,10F0,0F0F start a store.
// - Reads of 0000,1555,0AAA,1FFF,10F0,0F0E start a recall.
// - Host clocks each step with a select-framed read, never a write.
// - Host holds write enable high through all six unlock accesses.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_cfg.svh"

module nvsram_host_ctrl
  import nvc_pkg::*;
#(
  parameter int ADDR_W      = `ADDR_W,
  parameter int DATA_W      = `DATA_W,
  parameter int TW          = `TMR_W,
  parameter int STROBE_CYC  = ns_to_cyc(`STROBE_NS),
  parameter int RECALL_CYC  = ns_to_cyc(`RECALL_NS),
  parameter int STORE_CYC   = ns_to_cyc(`STORE_NS),
  parameter int RESTORE_CYC = ns_to_cyc(`RESTORE_NS)
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Supply monitor, high while above power_fail_threshold
  input  wire logic              power_good,
  // User command port
  input  wire logic              cmd_valid,
  input  wire logic [1:0]        cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic                   rsp_err,
  output logic [DATA_W-1:0]      rsp_rdata,
  // Memory pins
  output logic                   chip_select_n,
  output logic                   output_enable_n,
  output logic                   write_enable_n,
  output logic [ADDR_W-1:0]      address_lines,
  output logic [DATA_W-1:0]      data_lines_o,
  output logic                   data_lines_oe,
  input  wire logic [DATA_W-1:0] data_lines_i
);

  // ----------------------------------------------------------------
  // State and wait timer
  // ----------------------------------------------------------------
  state_e            state_r;
  state_e            state_nxt;
  op_e               op_r;
  logic [2:0]        step_r;
  logic [2:0]        step_nxt;
  logic              cs_n_r;
  logic              oe_n_r;
  logic              we_n_r;
  logic              dq_oe_r;
  logic              ready_r;
  logic              rsp_v_r;
  logic              rsp_e_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] dq_o_r;
  logic [DATA_W-1:0] rdata_r;

  tmr_if #(.W(TW)) tmr ();

  cycle_timer #(.W(TW)) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .t       (tmr)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire       take      = cmd_valid && ready_r && (state_r == ST_IDLE) && power_good;
  wire op_e  op_nxt    = take ? op_e'(cmd_op) : op_r;
  wire       unlock    = (op_r == OP_STORE) || (op_r == OP_RECALL);
  wire       recall    = (op_r == OP_RECALL);
  wire       seq_done  = (step_r == `SEQ_LAST_STEP);
  wire       in_access = (state_r == ST_SETUP) || (state_r == ST_STROBE)
                      || (state_r == ST_HOLD) || (state_r == ST_WAIT_NV);
  wire       abort     = !power_good && in_access;
  wire       strobe_n  = (state_nxt != ST_STROBE);
  // Data stays driven past a write's trailing edge, even when supply loss cuts it
  wire       drive_nxt = (op_nxt == OP_WRITE) && (!we_n_r || (state_nxt == ST_SETUP)
                      || (state_nxt == ST_STROBE) || (state_nxt == ST_HOLD));
  wire       done_nxt  = (state_nxt == ST_IDLE) && ((state_r == ST_HOLD)
                      || (state_r == ST_WAIT_NV));
  wire       capture   = (state_r == ST_STROBE) && (state_nxt == ST_HOLD)
                      && (op_r == OP_READ);

  // Address moves only while select is high; unlock steps walk the table
  wire [ADDR_W-1:0] addr_nxt =
      take ? (((op_nxt == OP_STORE) || (op_nxt == OP_RECALL))
              ? seq_addr(3'h0, op_nxt == OP_RECALL) : cmd_addr)
    : ((state_r == ST_HOLD) && (state_nxt == ST_SETUP))
              ? seq_addr(step_nxt, recall) : addr_r;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Supply loss overrides everything and rearms the power-up wait
  always_comb
  begin
    state_nxt = state_r;
    step_nxt  = step_r;
    tmr.load  = 1'b0;
    tmr.value = '0;
    case (state_r)
      ST_PWR_LOW:
      begin
        tmr.load  = 1'b1;
        tmr.value = TW'(RESTORE_CYC);
        if (power_good)
          state_nxt = ST_RESTORE;
      end
      ST_RESTORE:
        if (tmr.done)
          state_nxt = ST_IDLE;
      ST_IDLE:
        if (take)
        begin
          state_nxt = ST_SETUP;
          step_nxt  = 3'h0;
        end
      ST_SETUP:
      begin
        tmr.load  = 1'b1;
        tmr.value = TW'(STROBE_CYC);
        state_nxt = ST_STROBE;
      end
      ST_STROBE:
        if (tmr.done)
          state_nxt = ST_HOLD;
      ST_HOLD:
        if (unlock && !seq_done)
        begin
          // Steps follow back to back so no other access can intervene
          state_nxt = ST_SETUP;
          step_nxt  = step_r + 3'h1;
        end
        else if (unlock)
        begin
          tmr.load  = 1'b1;
          tmr.value = recall ? TW'(RECALL_CYC) : TW'(STORE_CYC);
          state_nxt = ST_WAIT_NV;
        end
        else
          state_nxt = ST_IDLE;
      ST_WAIT_NV:
        if (tmr.done)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_PWR_LOW;
    endcase
    if (!power_good)
    begin
      // No writes or stores go out below the threshold
      state_nxt = ST_PWR_LOW;
      tmr.load  = 1'b1;
      tmr.value = TW'(RESTORE_CYC);
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Sequence state and latched command
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_PWR_LOW;
      step_r  <= 3'h0;
      op_r    <= OP_READ;
    end
    else
    begin
      state_r <= state_nxt;
      step_r  <= step_nxt;
      op_r    <= op_nxt;
    end
  end

  // Pin strobes; write uses select plus write enable, output enable stays high
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_n_r  <= 1'b1;
      we_n_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      dq_oe_r <= 1'b0;
    end
    else
    begin
      cs_n_r  <= strobe_n;
      we_n_r  <= strobe_n || (op_nxt != OP_WRITE);
      oe_n_r  <= strobe_n || (op_nxt != OP_READ);
      dq_oe_r <= drive_nxt;
    end
  end

  // Address, write data and user answers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_r  <= '0;
      dq_o_r  <= '0;
      rdata_r <= '0;
      ready_r <= 1'b0;
      rsp_v_r <= 1'b0;
      rsp_e_r <= 1'b0;
    end
    else
    begin
      addr_r  <= addr_nxt;
      dq_o_r  <= take ? cmd_wdata : dq_o_r;
      rdata_r <= capture ? data_lines_i : rdata_r;
      ready_r <= (state_nxt == ST_IDLE);
      rsp_v_r <= done_nxt || abort;
      rsp_e_r <= abort;
    end
  end

  assign chip_select_n   = cs_n_r;
  assign output_enable_n = oe_n_r;
  assign write_enable_n  = we_n_r;
  assign address_lines   = addr_r;
  assign data_lines_o    = dq_o_r;
  assign data_lines_oe   = dq_oe_r;
  assign cmd_ready       = ready_r;
  assign rsp_valid       = rsp_v_r;
  assign rsp_err         = rsp_e_r;
  assign rsp_rdata       = rdata_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_addr_stable_select: assert property (
    (!cs_n_r && $past(!cs_n_r)) |-> $stable(addr_r))
    else $error("address moved while select low");

  a_data_at_trailing: assert property (
    ($rose(we_n_r) && cs_n_r) |-> (dq_oe_r && $stable(dq_o_r)) ##1 !dq_oe_r)
    else $error("write data not held through the trailing edge");

  a_oe_high_write: assert property (
    !we_n_r |-> (oe_n_r && !cs_n_r && dq_oe_r))
    else $error("output enable low during a write");

  a_quiet_in_restore: assert property (
    ((state_r == ST_RESTORE) || (state_r == ST_PWR_LOW)) |-> (cs_n_r && we_n_r))
    else $error("strobe active during power-up recall");

  a_store_last_addr: assert property (
    ($fell(cs_n_r) && (op_r == OP_STORE) && seq_done) |-> (addr_r == `SEQ_STORE_LAST))
    else $error("store sequence ends on the wrong address");

  a_recall_last_addr: assert property (
    ($fell(cs_n_r) && (op_r == OP_RECALL) && seq_done)
      |-> (addr_r == `SEQ_RECALL_LAST))
    else $error("recall sequence ends on the wrong address");

  a_unlock_read_only: assert property (
    ($fell(cs_n_r) && unlock) |-> (addr_r == seq_addr(step_r, recall)) && !dq_oe_r)
    else $error("unlock step is not a read of the expected address");

  a_unlock_we_high: assert property (
    (unlock && in_access) |-> we_n_r)
    else $error("write enable low inside an unlock sequence");

  a_nv_busy_quiet: assert property (
    ((state_r == ST_HOLD) && (state_nxt == ST_WAIT_NV))
      |=> (cs_n_r && !dq_oe_r) [*8])
    else $error("pins active during a nonvolatile cycle");

endmodule : nvsram_host_ctrl

`default_nettype wire

// >>> core/nvc_cfg.svh
// Constants for the nonvolatile SRAM host controller
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH

// ----------------------------------------------------------------
// Clock and bus widths
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define ADDR_W          13
`define DATA_W          8
`define TMR_W           20

// ----------------------------------------------------------------
// Times in ns, as printed or chosen
// ----------------------------------------------------------------
`define STROBE_NS       30
`define RECALL_NS       20000
`define STORE_NS        10000000
`define RESTORE_NS      550000

// ----------------------------------------------------------------
// Unlock address sequence
// ----------------------------------------------------------------
`define SEQ_ADDR_0      13'h0000
`define SEQ_ADDR_1      13'h1555
`define SEQ_ADDR_2      13'h0AAA
`define SEQ_ADDR_3      13'h1FFF
`define SEQ_ADDR_4      13'h10F0
`define SEQ_STORE_LAST  13'h0F0F
`define SEQ_RECALL_LAST 13'h0F0E
`define SEQ_LAST_STEP   3'h5

// ----------------------------------------------------------------
// Command op codes on the user port
// ----------------------------------------------------------------
`define OP_CODE_READ    2'h0
`define OP_CODE_WRITE   2'h1
`define OP_CODE_STORE   2'h2
`define OP_CODE_RECALL  2'h3

`endif

// >>> core/nvc_pkg.sv
// Types and helper functions for the nonvolatile SRAM host controller
`include "nvc_cfg.svh"

package nvc_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_PWR_LOW,
    ST_RESTORE,
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_WAIT_NV
  } state_e;

  typedef enum logic [1:0] {
    OP_READ   = `OP_CODE_READ,
    OP_WRITE  = `OP_CODE_WRITE,
    OP_STORE  = `OP_CODE_STORE,
    OP_RECALL = `OP_CODE_RECALL
  } op_e;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Least time in ns to whole clock cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  // Address of one unlock step; the last step picks store or recall
  function automatic logic [`ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                  input logic       recall);
    logic [`ADDR_W-1:0] a;
    case (step)
      3'h0:    a = `SEQ_ADDR_0;
      3'h1:    a = `SEQ_ADDR_1;
      3'h2:    a = `SEQ_ADDR_2;
      3'h3:    a = `SEQ_ADDR_3;
      3'h4:    a = `SEQ_ADDR_4;
      default: a = recall ? `SEQ_RECALL_LAST : `SEQ_STORE_LAST;
    endcase
    return a;
  endfunction : seq_addr

endpackage : nvc_pkg

// >>> core/tmr_if.sv
// Load and done signals between the controller and its wait timer
`timescale 1ns/1ps
`default_nettype none

interface tmr_if #(parameter int W = 20);
  logic         load;
  logic [W-1:0] value;
  logic         done;

  modport ctrl (output load, output value, input done);
  modport tmr  (input load, input value, output done);
endinterface : tmr_if

`default_nettype wire

// >>> core/cycle_timer.sv
// Down-counter that measures strobe widths and nonvolatile busy times
`timescale 1ns/1ps
`default_nettype none

module cycle_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Control side
  tmr_if.tmr        t
);

  logic [W-1:0] cnt_r;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Load wins over counting, so a reload restarts the wait
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (t.load)
      cnt_r <= t.value;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - W'(1);
  end

  // Done straight from the count, no extra pipeline stage
  assign t.done = (cnt_r == '0);

endmodule : cycle_timer

`default_nettype wire

// >>> verif/nvsram_model.sv
// Behavioural model of the 8K x 8 nonvolatile SRAM seen on the memory pins
`timescale 1ns/1ps
`default_nettype none

module nvsram_model #(
  parameter int STORE_T   = 200,
  parameter int RECALL_T  = 100,
  parameter int RESTORE_T = 150
) (
  // Supply
  input  wire logic        power_good,
  // Strobes and address
  input  wire logic        chip_select_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic [12:0] address_lines,
  // Shared data bus
  input  wire logic [7:0]  host_d,
  input  wire logic        host_oe,
  output logic [7:0]       data_lines
);
  // ----------------------------------------------------------------
  // Arrays and state
  // ----------------------------------------------------------------
  logic [7:0]  sram [8192];
  logic [7:0]  nv   [8192];
  logic [12:0] seq  [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
  logic [2:0]  step    = 3'h0;
  logic        busy    = 1'b1;
  logic        written = 1'b0;
  logic        wr_seen = 1'b0;
  logic [7:0]  last_q  = 8'h00;
  wire         rd_en   = !chip_select_n && !output_enable_n && write_enable_n
                         && !busy && power_good;
  wire         wr_act  = !chip_select_n && !write_enable_n;

  // Released bus shows the inverse of the last byte, never a stale copy
  assign data_lines = rd_en ? sram[address_lines] : (host_oe ? host_d : ~last_q);

  // Clear then copy; nonvolatile side is only read
  task recall_run(input int t);
    busy = 1'b1;
    sram = '{default: 8'h00};
    #(t);
    sram = nv;
    written = 1'b0;
    step = 3'h0;
    busy = 1'b0;
  endtask : recall_run

  // Runs whether written or not; the caller blocks, so accesses are lost
  task store_run();
    busy = 1'b1;
    #(STORE_T);
    nv = sram;
    written = 1'b0;
    busy = 1'b0;
  endtask : store_run

  // Power-up contents, arbitrary but address dependent
  initial
  begin
    foreach (nv[i]) nv[i] = i[7:0] ^ 8'hA5;
    recall_run(RESTORE_T);
  end

  // Byte taken at the trailing edge of either strobe
  always @(negedge wr_act)
  begin
    wr_seen = 1'b1;
    if (power_good && !busy)
    begin
      sram[address_lines] = host_d;
      written = 1'b1;
      step = 3'h0;
    end
  end

  // Unlock tracker clocked by select-framed reads; the short wait lets strobes
  // that rise on the same edge settle, and a write frame never counts as a step
  always @(posedge chip_select_n)
  begin
    #1;
    last_q = sram[address_lines];
    if (!wr_seen && !busy && power_good)
    begin
      if (step < 3'h5)
        step = (address_lines == seq[step]) ? step + 3'h1 :
               {2'b00, address_lines == 13'h0000};
      else
      begin
        step = 3'h0;
        if (address_lines == 13'h0F0F)
          store_run();
        else if (address_lines == 13'h0F0E)
          recall_run(RECALL_T);
      end
    end
    wr_seen = 1'b0;
  end

  // Supply loss stores only if written since the last transfer
  always @(negedge power_good)
  begin
    step = 3'h0;
    if (written)
      nv = sram;
    written = 1'b0;
  end

  // Supply back: pending recall
  always @(posedge power_good)
    recall_run(RESTORE_T);

endmodule : nvsram_model

`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the nonvolatile SRAM host controller
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import nvc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        ref_clk    = 1'b0;
  logic        rst_n      = 1'b0;
  logic        power_good = 1'b1;
  logic        cmd_valid  = 1'b0;
  logic [1:0]  cmd_op     = 2'h0;
  logic [12:0] cmd_addr   = 13'h0000;
  logic [7:0]  cmd_wdata  = 8'h00;
  wire  logic  cmd_ready, rsp_valid, rsp_err, chip_select_n, output_enable_n, write_enable_n;
  wire  logic  data_lines_oe;
  wire  logic [7:0]  rsp_rdata, data_lines_o, data_lines_i;
  wire  logic [12:0] address_lines;
  logic        prev_cs    = 1'b0;
  logic [12:0] prev_addr  = 13'h0000;
  int          fail_count = 0;
  int          checked    = 0;

  always #5 ref_clk = ~ref_clk;

  nvsram_host_ctrl #(.STORE_CYC(50), .RESTORE_CYC(20), .RECALL_CYC(20)) dut (
    .ref_clk, .rst_n, .power_good, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata,
    .cmd_ready, .rsp_valid, .rsp_err, .rsp_rdata, .chip_select_n, .output_enable_n,
    .write_enable_n, .address_lines, .data_lines_o, .data_lines_oe, .data_lines_i);

  nvsram_model u_mem (
    .power_good, .chip_select_n, .output_enable_n, .write_enable_n, .address_lines,
    .host_d(data_lines_o), .host_oe(data_lines_oe), .data_lines(data_lines_i));

  // ----------------------------------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // A hang is a mismatch and ends the run
  task automatic give_up(input string m);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
    print_verdict();
  endtask : give_up

  task automatic issue(input op_e op, input logic [12:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 1000);
    if (n >= 1000) give_up("command never taken");
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
  endtask : issue

  task automatic finish(output logic [7:0] rd, output logic err);
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 1000);
    if (n >= 1000) give_up("no response");
    rd = rsp_rdata;
    err = rsp_err;
  endtask : finish

  task automatic xfer(input op_e op, input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    issue(op, a, d);
    finish(r, e);
    chk(16'(e), 16'h0000, "error flag on a clean command");
  endtask : xfer

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] x, input string m);
    logic [7:0] r;
    logic       e;
    issue(OP_READ, a, 8'h00);
    finish(r, e);
    chk(16'(r), 16'(x), m);
  endtask : rd_chk

  // Pin watch: no address movement under select, quiet output enable on writes
  always @(posedge ref_clk)
  begin
    prev_cs <= rst_n && !chip_select_n;
    prev_addr <= address_lines;
    if (rst_n && !chip_select_n && !write_enable_n)
      chk(16'({output_enable_n, data_lines_oe}), 16'h0003, "write strobes");
    if (rst_n && !chip_select_n && prev_cs)
      chk(16'(address_lines), 16'(prev_addr), "address under select");
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_rw();
    logic [12:0] a [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
    rd_chk(13'h0040, 8'hE5, "power-up contents");
    foreach (a[i]) xfer(OP_WRITE, a[i], 8'h3C ^ a[i][7:0]);
    foreach (a[i]) rd_chk(a[i], 8'h3C ^ a[i][7:0], "read back");
  endtask : s_rw

  // Store, overwrite, then recall twice to get the stored byte back
  task automatic s_sw();
    xfer(OP_WRITE, 13'h0200, 8'h11);
    xfer(OP_STORE, 13'h0000, 8'h00);
    xfer(OP_WRITE, 13'h0200, 8'h22);
    rd_chk(13'h0200, 8'h22, "sram usable after store");
    repeat (2)
    begin
      xfer(OP_RECALL, 13'h0000, 8'h00);
      rd_chk(13'h0200, 8'h11, "recalled byte");
    end
  endtask : s_sw

  // Supply loss after a write keeps that byte across the outage
  task automatic s_pwr();
    xfer(OP_WRITE, 13'h0300, 8'h5A);
    @(posedge ref_clk);
    power_good <= 1'b0;
    repeat (5) @(negedge ref_clk);
    chk(16'(cmd_ready), 16'h0000, "ready with supply low");
    @(posedge ref_clk);
    power_good <= 1'b1;
    rd_chk(13'h0300, 8'h5A, "byte kept over outage");
  endtask : s_pwr

  // Outage in mid-sequence aborts it; a fresh sequence still works
  task automatic s_abort();
    logic [7:0] r;
    logic       e;
    issue(OP_STORE, 13'h0000, 8'h00);
    repeat (12) @(posedge ref_clk);
    power_good <= 1'b0;
    finish(r, e);
    chk(16'(e), 16'h0001, "abort flag");
    @(posedge ref_clk);
    power_good <= 1'b1;
    rd_chk(13'h0300, 8'h5A, "contents after abort");
    xfer(OP_WRITE, 13'h0300, 8'h77);
    xfer(OP_STORE, 13'h0000, 8'h00);
    xfer(OP_WRITE, 13'h0300, 8'h00);
    xfer(OP_RECALL, 13'h0000, 8'h00);
    rd_chk(13'h0300, 8'h77, "store after restart");
  endtask : s_abort

  // Main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_rw();
    s_sw();
    s_pwr();
    s_abort();
    print_verdict();
  end

endmodule : tb_top

`default_nettype wire
